//--- hw/rmh_pkg.sv
package rmh_pkg;

  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int WORD_W = 16;
  localparam int SYNC_W = 8;

  // Register byte addresses.
  localparam logic [AXI_AW-1:0] SYNC_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] MBOX_OFS = 8'h04;
  localparam logic [AXI_AW-1:0] STAT_OFS = 8'h20;
  localparam logic [AXI_AW-1:0] VAL_OFS = 8'h40;

  // Synchronising byte bit positions.
  localparam int SB_LOCKED = 0;
  localparam int SB_FAULTY = 1;
  localparam int SB_GOOD = 2;
  localparam int SB_DONE = 3;
  localparam int SB_DATA_REQ = 4;
  localparam int SB_READ_MBOX = 5;
  localparam int SB_LOCK_REQ = 6;

  // Bits whose value the controller stores with a plain write.
  localparam logic [SYNC_W-1:0] SYNC_CTRL_MASK = 8'h76;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h00;

  // Mailbox layout.
  localparam int MBOX_WORDS = 5;
  localparam int MB_RECIPE = 0;
  localparam int MB_RECORD = 3;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  // Status register fields.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_BUSY = 4;
  localparam int ST_LAST_OK = 5;
  localparam int ST_LOCK_ERR = 6;
  localparam int ST_REQ_MODE = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_LOCK,
    ST_WRITE_ID,
    ST_WALK,
    ST_WAIT_ACK,
    ST_WAIT_RELEASE,
    ST_REQ_WAIT
  } rmh_state_e;

endpackage : rmh_pkg

//--- hw/rmh_walk_if.sv
`timescale 1ns/100ps
interface rmh_walk_if #(
  parameter int IDX_W = 2,
  parameter int VADDR_W = 16
);
  logic start;
  logic busy;
  logic item_valid;
  logic item_ready;
  logic [IDX_W-1:0] item_idx;
  logic [15:0] item_val;
  logic [VADDR_W-1:0] item_addr;

  modport walker (
    input start,
    input item_ready,
    output busy,
    output item_valid,
    output item_idx,
    output item_val,
    output item_addr
  );

  modport core (
    output start,
    output item_ready,
    input busy,
    input item_valid,
    input item_idx,
    input item_val,
    input item_addr
  );
endinterface : rmh_walk_if

//--- hw/rmh_var_walker.sv
`timescale 1ns/100ps
module rmh_var_walker import rmh_pkg::*; #(
  parameter int N_VARS = 4,
  parameter int IDX_W = 2,
  parameter int VADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  rmh_walk_if.walker walk,
  input wire logic [N_VARS*WORD_W-1:0] var_value,
  input wire logic [N_VARS*VADDR_W-1:0] var_addr,
  input wire logic [N_VARS-1:0] var_assigned
);

  logic busy_reg;
  logic busy_next;
  logic [IDX_W-1:0] idx_reg;
  logic [IDX_W-1:0] idx_next;
  logic advance;

  // Values are taken live from the panel's working copy, never reloaded.
  assign walk.item_val = var_value[idx_reg*WORD_W +: WORD_W];
  assign walk.item_addr = var_addr[idx_reg*VADDR_W +: VADDR_W];
  assign walk.item_idx = idx_reg;
  assign walk.busy = busy_reg;
  assign walk.item_valid = busy_reg && var_assigned[idx_reg];

  always_comb begin
    busy_next = busy_reg;
    idx_next = idx_reg;
    // Variables without a controller address are stepped over.
    advance = busy_reg && (!var_assigned[idx_reg] || walk.item_ready);
    if (!busy_reg && walk.start) begin
      busy_next = 1'b1;
      idx_next = '0;
    end else if (advance) begin
      if (idx_reg == IDX_W'(N_VARS - 1)) begin
        busy_next = 1'b0;
      end else begin
        idx_next = idx_reg + IDX_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      idx_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      idx_reg <= idx_next;
    end
  end

endmodule : rmh_var_walker

//--- hw/rmh_mailbox.sv
`timescale 1ns/100ps
module rmh_mailbox import rmh_pkg::*; #(
  parameter int N_VARS = 4,
  parameter int VADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic xfer_start,
  input wire logic [WORD_W-1:0] recipe_num,
  input wire logic [WORD_W-1:0] record_num,
  input wire logic direct_mode,
  input wire logic [N_VARS*WORD_W-1:0] var_value,
  input wire logic [N_VARS*VADDR_W-1:0] var_addr,
  input wire logic [N_VARS-1:0] var_assigned,
  output logic xfer_busy,
  output logic xfer_done,
  output logic xfer_ok,
  output logic lock_error,
  output logic req_valid,
  output logic [WORD_W-1:0] req_recipe,
  output logic [WORD_W-1:0] req_record,
  output logic var_wr_valid,
  output logic [VADDR_W-1:0] var_wr_addr,
  output logic [WORD_W-1:0] var_wr_data,
  input wire logic var_wr_ready
);

  localparam int IDX_W = (N_VARS > 1) ? $clog2(N_VARS) : 1;

  function automatic logic [AXI_DW-1:0] merge_strb(input logic [AXI_DW-1:0] old,
                                                   input logic [AXI_DW-1:0] data,
                                                   input logic [3:0] strb);
    logic [AXI_DW-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // Word index inside an area, or -1 when the address misses it.
  function automatic int area_index(input logic [AXI_AW-1:0] addr,
                                    input logic [AXI_AW-1:0] base,
                                    input int words);
    int res;
    res = -1;
    if (addr[1:0] == 2'h0 && addr >= base && int'(addr - base) < 4 * words) begin
      res = int'(addr - base) / 4;
    end
    return res;
  endfunction : area_index

  rmh_walk_if #(.IDX_W(IDX_W), .VADDR_W(VADDR_W)) walk ();

  rmh_var_walker #(.N_VARS(N_VARS), .IDX_W(IDX_W), .VADDR_W(VADDR_W)) u_walker (
    .aclk(aclk),
    .aresetn(aresetn),
    .walk(walk.walker),
    .var_value(var_value),
    .var_addr(var_addr),
    .var_assigned(var_assigned)
  );

  rmh_state_e state_reg, state_next;
  logic [SYNC_W-1:0] sync_reg, sync_next;
  logic [WORD_W-1:0] mbox_reg [MBOX_WORDS];
  logic [WORD_W-1:0] mbox_next [MBOX_WORDS];
  logic [WORD_W-1:0] val_reg [N_VARS];
  logic [WORD_W-1:0] val_next [N_VARS];
  logic [WORD_W-1:0] id_recipe_reg, id_recipe_next;
  logic [WORD_W-1:0] id_record_reg, id_record_next;
  logic [WORD_W-1:0] req_recipe_reg, req_recipe_next;
  logic [WORD_W-1:0] req_record_reg, req_record_next;
  logic req_mode_reg, req_mode_next;
  logic last_ok_reg, last_ok_next;
  logic lock_err_seen_reg, lock_err_seen_next;
  logic done_reg, done_next;
  logic lock_error_reg, lock_error_next;
  logic req_valid_reg, req_valid_next;
  logic var_wr_valid_reg, var_wr_valid_next;
  logic [VADDR_W-1:0] var_wr_addr_reg, var_wr_addr_next;
  logic [WORD_W-1:0] var_wr_data_reg, var_wr_data_next;

  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [AXI_DW-1:0] rdata_reg, rdata_next;
  logic wr_fire;
  logic rd_fire;
  logic [AXI_DW-1:0] sync_wr;
  int wr_mbox;
  int rd_mbox;
  int rd_val;

  // Address and data are taken together, only while no response is pending.
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign wr_mbox = area_index(s_axi_awaddr, MBOX_OFS, MBOX_WORDS);
  assign rd_mbox = area_index(s_axi_araddr, MBOX_OFS, MBOX_WORDS);
  assign rd_val = area_index(s_axi_araddr, VAL_OFS, N_VARS);
  assign sync_wr = merge_strb({24'h000000, sync_reg}, s_axi_wdata, s_axi_wstrb);

  assign walk.start = (state_reg == ST_WRITE_ID);
  assign walk.item_ready = direct_mode ? !var_wr_valid_reg : 1'b1;

  assign xfer_busy = (state_reg != ST_IDLE);
  assign xfer_done = done_reg;
  assign xfer_ok = last_ok_reg;
  assign lock_error = lock_error_reg;
  assign req_valid = req_valid_reg;
  assign req_recipe = req_recipe_reg;
  assign req_record = req_record_reg;
  assign var_wr_valid = var_wr_valid_reg;
  assign var_wr_addr = var_wr_addr_reg;
  assign var_wr_data = var_wr_data_reg;

  always_comb begin
    state_next = state_reg;
    sync_next = sync_reg;
    mbox_next = mbox_reg;
    val_next = val_reg;
    id_recipe_next = id_recipe_reg;
    id_record_next = id_record_reg;
    req_recipe_next = req_recipe_reg;
    req_record_next = req_record_reg;
    req_mode_next = req_mode_reg;
    last_ok_next = last_ok_reg;
    lock_err_seen_next = lock_err_seen_reg;
    done_next = 1'b0;
    lock_error_next = 1'b0;
    req_valid_next = 1'b0;
    var_wr_valid_next = var_wr_valid_reg;
    var_wr_addr_next = var_wr_addr_reg;
    var_wr_data_next = var_wr_data_reg;

    // Controller writes come first; the panel's own updates below win.
    if (wr_fire) begin
      if (s_axi_awaddr == SYNC_OFS) begin
        sync_next = (sync_reg & ~SYNC_CTRL_MASK) | (sync_wr[SYNC_W-1:0] & SYNC_CTRL_MASK);
        if (!sync_wr[SB_LOCKED]) begin
          sync_next[SB_LOCKED] = 1'b0;
        end
      end else if (wr_mbox >= 0) begin
        mbox_next[wr_mbox] = WORD_W'(merge_strb({16'h0000, mbox_reg[wr_mbox]}, s_axi_wdata,
                                                s_axi_wstrb));
      end
    end

    if (var_wr_valid_reg && var_wr_ready) begin
      var_wr_valid_next = 1'b0;
    end

    // A start that meets the lock held for the controller is refused with an error.
    if (xfer_start && req_mode_reg && state_reg != ST_IDLE && sync_reg[SB_LOCKED]) begin
      lock_error_next = !lock_error_reg;
      lock_err_seen_next = 1'b1;
    end

    case (state_reg)
      ST_IDLE: begin
        if (xfer_start) begin
          id_recipe_next = recipe_num;
          id_record_next = record_num;
          req_mode_next = 1'b0;
          state_next = ST_LOCK;
        end else if (sync_reg[SB_LOCK_REQ] && !sync_reg[SB_LOCKED]) begin
          sync_next[SB_LOCKED] = 1'b1;
          sync_next[SB_LOCK_REQ] = 1'b0;
          req_mode_next = 1'b1;
          state_next = ST_REQ_WAIT;
        end
      end
      ST_LOCK: begin
        if (sync_reg[SB_LOCKED]) begin
          lock_error_next = 1'b1;
          lock_err_seen_next = 1'b1;
          state_next = ST_IDLE;
        end else begin
          sync_next[SB_LOCKED] = 1'b1;
          state_next = ST_WRITE_ID;
        end
      end
      ST_REQ_WAIT: begin
        if (sync_reg[SB_DATA_REQ]) begin
          id_recipe_next = mbox_reg[MB_RECIPE];
          id_record_next = mbox_reg[MB_RECORD];
          req_recipe_next = mbox_reg[MB_RECIPE];
          req_record_next = mbox_reg[MB_RECORD];
          req_valid_next = 1'b1;
          sync_next[SB_DATA_REQ] = 1'b0;
          state_next = ST_WRITE_ID;
        end
      end
      ST_WRITE_ID: begin
        mbox_next[MB_RECIPE] = id_recipe_reg;
        mbox_next[MB_RECORD] = id_record_reg;
        state_next = ST_WALK;
      end
      ST_WALK: begin
        if (walk.item_valid && walk.item_ready) begin
          if (direct_mode) begin
            var_wr_valid_next = 1'b1;
            var_wr_addr_next = walk.item_addr;
            var_wr_data_next = walk.item_val;
          end else begin
            val_next[walk.item_idx] = walk.item_val;
          end
        end
        if (!walk.busy && !var_wr_valid_reg) begin
          sync_next[SB_DONE] = 1'b1;
          state_next = ST_WAIT_ACK;
        end
      end
      ST_WAIT_ACK: begin
        if (sync_reg[SB_GOOD] || sync_reg[SB_FAULTY]) begin
          last_ok_next = sync_reg[SB_GOOD] && !sync_reg[SB_FAULTY];
          state_next = ST_WAIT_RELEASE;
        end
      end
      ST_WAIT_RELEASE: begin
        if (!sync_reg[SB_LOCKED]) begin
          sync_next[SB_DONE] = 1'b0;
          sync_next[SB_GOOD] = 1'b0;
          sync_next[SB_FAULTY] = 1'b0;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    sync_next[SYNC_W-1] = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      sync_reg <= SYNC_RST;
      for (int i = 0; i < MBOX_WORDS; i++) begin
        mbox_reg[i] <= WORD_RST;
      end
      for (int i = 0; i < N_VARS; i++) begin
        val_reg[i] <= WORD_RST;
      end
      id_recipe_reg <= WORD_RST;
      id_record_reg <= WORD_RST;
      req_recipe_reg <= WORD_RST;
      req_record_reg <= WORD_RST;
      req_mode_reg <= 1'b0;
      last_ok_reg <= 1'b0;
      lock_err_seen_reg <= 1'b0;
      done_reg <= 1'b0;
      lock_error_reg <= 1'b0;
      req_valid_reg <= 1'b0;
      var_wr_valid_reg <= 1'b0;
      var_wr_addr_reg <= '0;
      var_wr_data_reg <= WORD_RST;
    end else begin
      state_reg <= state_next;
      sync_reg <= sync_next;
      mbox_reg <= mbox_next;
      val_reg <= val_next;
      id_recipe_reg <= id_recipe_next;
      id_record_reg <= id_record_next;
      req_recipe_reg <= req_recipe_next;
      req_record_reg <= req_record_next;
      req_mode_reg <= req_mode_next;
      last_ok_reg <= last_ok_next;
      lock_err_seen_reg <= lock_err_seen_next;
      done_reg <= done_next;
      lock_error_reg <= lock_error_next;
      req_valid_reg <= req_valid_next;
      var_wr_valid_reg <= var_wr_valid_next;
      var_wr_addr_reg <= var_wr_addr_next;
      var_wr_data_reg <= var_wr_data_next;
    end
  end

  always_comb begin
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      bvalid_next = 1'b1;
      if (s_axi_awaddr == SYNC_OFS || wr_mbox >= 0) begin
        bresp_next = RESP_OKAY;
      end else begin
        bresp_next = RESP_SLVERR;
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = '0;
      if (s_axi_araddr == SYNC_OFS) begin
        rdata_next[SYNC_W-1:0] = sync_reg;
      end else if (rd_mbox >= 0) begin
        rdata_next[WORD_W-1:0] = mbox_reg[rd_mbox];
      end else if (s_axi_araddr == STAT_OFS) begin
        rdata_next[ST_STATE_LSB +: 4] = state_reg;
        rdata_next[ST_BUSY] = (state_reg != ST_IDLE);
        rdata_next[ST_LAST_OK] = last_ok_reg;
        rdata_next[ST_LOCK_ERR] = lock_err_seen_reg;
        rdata_next[ST_REQ_MODE] = req_mode_reg;
      end else if (rd_val >= 0) begin
        rdata_next[WORD_W-1:0] = val_reg[rd_val];
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else begin
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

endmodule : rmh_mailbox

//--- test/rmh_checker.sv
`timescale 1ns/100ps
module rmh_checker #(
  parameter int VADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic xfer_start,
  input wire logic xfer_busy,
  input wire logic xfer_done,
  input wire logic xfer_ok,
  input wire logic lock_error,
  input wire logic req_valid,
  input wire logic var_wr_valid,
  input wire logic [VADDR_W-1:0] var_wr_addr,
  input wire logic [15:0] var_wr_data,
  input wire logic var_wr_ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (
    s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write take not answered next cycle");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_start_busy: assert property (
    xfer_start && !xfer_busy |=> xfer_busy)
    else $error("idle start did not make busy");
  a_error_pulse: assert property (
    lock_error |=> !lock_error)
    else $error("lock error longer than one cycle");
  a_done_idle: assert property (
    xfer_done |-> !xfer_busy ##1 !xfer_done)
    else $error("done pulse wrong");
  a_req_pulse: assert property (
    req_valid |-> xfer_busy ##1 !req_valid)
    else $error("request pulse wrong");
  a_varwr_hold: assert property (
    var_wr_valid && !var_wr_ready |=>
      var_wr_valid && $stable(var_wr_addr) && $stable(var_wr_data))
    else $error("direct write dropped before ready");
  a_varwr_busy: assert property (
    var_wr_valid |-> xfer_busy)
    else $error("direct write while idle");

  c_lock_err: cover property (lock_error);
  c_request: cover property (req_valid);
  c_good_end: cover property (xfer_done && xfer_ok);
endmodule : rmh_checker

bind rmh_mailbox rmh_checker #(.VADDR_W(VADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .xfer_start(xfer_start), .xfer_busy(xfer_busy),
  .xfer_done(xfer_done), .xfer_ok(xfer_ok), .lock_error(lock_error),
  .req_valid(req_valid), .var_wr_valid(var_wr_valid), .var_wr_addr(var_wr_addr),
  .var_wr_data(var_wr_data), .var_wr_ready(var_wr_ready));

//--- test/rmh_ctrl_model.sv
`timescale 1ns/100ps
module rmh_ctrl_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic var_wr_valid,
  input wire logic [15:0] var_wr_addr,
  input wire logic [15:0] var_wr_data,
  output logic var_wr_ready
);
  logic [1:0] cnt;
  int n_wr;
  logic [15:0] la [8];
  logic [15:0] ld [8];

  // When slow, memory accepts only one cycle in four.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 2'h0;
      n_wr <= 0;
      var_wr_ready <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      var_wr_ready <= !slow || cnt == 2'h2;
      if (var_wr_valid && var_wr_ready && n_wr < 8) begin
        la[n_wr] <= var_wr_addr;
        ld[n_wr] <= var_wr_data;
        n_wr <= n_wr + 1;
      end
    end
  end
endmodule : rmh_ctrl_model

//--- test/tb_top.sv
`timescale 1ns/100ps
module tb_top import rmh_pkg::*;;
  logic aclk, aresetn, awv, wv, bv, br, awr, wr, arv, arr, rv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, d;
  logic [1:0] bresp, rresp, r;
  logic xs, dm, busy, done, ok, lerr, rqv, wvv, wrdy, slow, sawl, sawr;
  logic [15:0] rnum, cnum, rrcp, rrec, waddr, wdat;
  logic [63:0] vval, vadr;
  logic [3:0] vasg;
  int mismatches, n_tests, i, n_done;
  int vi [3] = '{0, 1, 3};

  rmh_mailbox #(.N_VARS(4), .VADDR_W(16)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .xfer_start(xs), .recipe_num(rnum), .record_num(cnum),
    .direct_mode(dm), .var_value(vval), .var_addr(vadr), .var_assigned(vasg),
    .xfer_busy(busy), .xfer_done(done), .xfer_ok(ok), .lock_error(lerr),
    .req_valid(rqv), .req_recipe(rrcp), .req_record(rrec), .var_wr_valid(wvv),
    .var_wr_addr(waddr), .var_wr_data(wdat), .var_wr_ready(wrdy));

  rmh_ctrl_model u_ctrl (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .var_wr_valid(wvv), .var_wr_addr(waddr), .var_wr_data(wdat), .var_wr_ready(wrdy));

  always #2.5 aclk = ~aclk;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sawl <= 1'b0;
      sawr <= 1'b0;
      n_done <= 0;
    end else begin
      if (lerr === 1'b1) sawl <= 1'b1;
      if (rqv === 1'b1) sawr <= 1'b1;
      if (done === 1'b1) n_done <= n_done + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Every handshake is judged at the rising edge that completes it.
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] q);
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do @(posedge aclk);
    while (awr !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge aclk);
    while (bv !== 1'b1);
    q = bresp;
    br <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge aclk);
    while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk);
    while (rv !== 1'b1);
    v = rd;
    q = rresp;
    rr <= 1'b0;
  endtask : axr

  task automatic wo(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] q;
    axw(a, v, q);
    chk("bresp", {30'h0, q}, {30'h0, RESP_OKAY});
  endtask : wo

  task automatic ro(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    logic [1:0] q;
    axr(a, v, q);
    chk(nm, v, e);
  endtask : ro

  task automatic wait_bit(input int b);
    logic [31:0] v;
    logic [1:0] q;
    do axr(SYNC_OFS, v, q);
    while (v[b] !== 1'b1);
  endtask : wait_bit

  task automatic go;
    @(posedge aclk);
    xs <= 1'b1;
    @(posedge aclk);
    xs <= 1'b0;
  endtask : go

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    test_done();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awv, wv, br, arv, rr, xs, dm, slow} = '0;
    {awa, ara, wd, rnum, cnum} = '0;
    vval = 64'h4444_3333_2222_1111;
    vadr = 64'h1003_1002_1001_1000;
    vasg = 4'b1011;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    ro(SYNC_OFS, 32'h0, "sync reset");
    ro(MBOX_OFS + 8'h0C, 32'h0, "record reset");
    axr(8'hFC, d, r);
    chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    axw(STAT_OFS, 32'hF, r);
    chk("status write", {30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test reset done");
    rnum <= 16'h0012;
    cnum <= 16'h0034;
    go();
    wait_bit(SB_DONE);
    ro(SYNC_OFS, 32'h09, "sync complete");
    ro(MBOX_OFS, 32'h12, "recipe word");
    ro(MBOX_OFS + 8'h0C, 32'h34, "record word");
    for (i = 0; i < 4; i++) begin
      ro(VAL_OFS + 8'(4 * i), {16'h0, vasg[i] ? vval[16*i+:16] : 16'h0}, "value");
    end
    wo(SYNC_OFS, 32'h05);
    wo(SYNC_OFS, 32'h04);
    while (busy !== 1'b0) @(posedge aclk);
    ro(SYNC_OFS, 32'h0, "sync end");
    chk("ok good", {31'h0, ok}, 32'h1);
    chk("done count", n_done, 32'd1);
    $display("test panel transfer done");
    vval <= 64'hDDDD_CCCC_BBBB_AAAA;
    dm <= 1'b1;
    slow <= 1'b1;
    wo(SYNC_OFS, 32'h40);
    ro(SYNC_OFS, 32'h01, "lock grant");
    go();
    repeat (4) @(posedge aclk);
    chk("lock error", {31'h0, sawl}, 32'h1);
    wo(MBOX_OFS, 32'h56);
    wo(MBOX_OFS + 8'h0C, 32'h78);
    wo(SYNC_OFS, 32'h11);
    wait_bit(SB_DONE);
    chk("req seen", {31'h0, sawr}, 32'h1);
    chk("req recipe", {16'h0, rrcp}, 32'h56);
    chk("req record", {16'h0, rrec}, 32'h78);
    ro(SYNC_OFS, 32'h09, "sync request");
    chk("write count", u_ctrl.n_wr, 32'd3);
    for (i = 0; i < 3; i++) begin
      chk("wr addr", {16'h0, u_ctrl.la[i]}, {16'h0, vadr[16*vi[i]+:16]});
      chk("wr data", {16'h0, u_ctrl.ld[i]}, {16'h0, vval[16*vi[i]+:16]});
    end
    wo(SYNC_OFS, 32'h03);
    wo(SYNC_OFS, 32'h02);
    while (busy !== 1'b0) @(posedge aclk);
    ro(SYNC_OFS, 32'h0, "sync end");
    chk("ok faulty", {31'h0, ok}, 32'h0);
    chk("done count", n_done, 32'd2);
    ro(STAT_OFS, 32'hC0, "status");
    $display("test controller request done");
    test_done();
  end
endmodule : tb_top
